/* File: tap_params.svh */
`ifndef TAP_PARAMS_SVH
`define TAP_PARAMS_SVH
`define TAP_IR_W        3
`define TAP_BSR_W       109
`define TAP_ID_W        32
`define TAP_OE_BIT      108
`define TAP_RESET_TMS_N 5
`define TAP_IR_CAPTURE  3'h1
`define TAP_OP_EXTEST   3'h0
`define TAP_OP_IDCODE   3'h1
`define TAP_OP_HIGHZ    3'h2
`define TAP_OP_SAMPLE   3'h4
`define TAP_OP_BYPASS   3'h7
`define TAP_REV_VAL     3'h5
`define TAP_PART_VAL    17'h0a5a5
`define TAP_MAKER_VAL   11'h2a5
`endif

/* File: tap_pkg.sv */
package tap_pkg;
    typedef enum logic [3:0] {
        ST_RESET     = 4'b0000,
        ST_IDLE      = 4'b0001,
        ST_SEL_DR    = 4'b0010,
        ST_CAP_DR    = 4'b0011,
        ST_SHIFT_DR  = 4'b0100,
        ST_EXIT1_DR  = 4'b0101,
        ST_PAUSE_DR  = 4'b0110,
        ST_EXIT2_DR  = 4'b0111,
        ST_UPD_DR    = 4'b1000,
        ST_SEL_IR    = 4'b1001,
        ST_CAP_IR    = 4'b1010,
        ST_SHIFT_IR  = 4'b1011,
        ST_EXIT1_IR  = 4'b1100,
        ST_PAUSE_IR  = 4'b1101,
        ST_EXIT2_IR  = 4'b1110,
        ST_UPD_IR    = 4'b1111
    } tap_state_t;
endpackage

/* File: tap_pins_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface tap_pins_if;
    logic tck_rise;
    logic tck_fall;
    logic tms;
    logic tdi;
    modport src (output tck_rise, output tck_fall, output tms, output tdi);
    modport dst (input tck_rise, input tck_fall, input tms, input tdi);
endinterface
`default_nettype wire

/* File: tap_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module tap_pin_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Raw pins
    input  wire logic tck,
    input  wire logic tms,
    input  wire logic tdi,
    // Synchronised pins and edges
    tap_pins_if.src   pins
);
    logic [2:0] s1;
    logic [2:0] s2;
    logic       tck_d;
    logic [2:0] next_s1;
    logic [2:0] next_s2;
    logic       next_tck_d;

    always_comb begin
        next_s1    = {tck, tms, tdi};
        next_s2    = s1;
        next_tck_d = s2[2];
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s1    <= 3'h0;
            s2    <= 3'h0;
            tck_d <= 1'b0;
        end else begin
            s1    <= next_s1;
            s2    <= next_s2;
            tck_d <= next_tck_d;
        end
    end

    assign pins.tck_rise = s2[2] & ~tck_d;
    assign pins.tck_fall = ~s2[2] & tck_d;
    assign pins.tms      = s2[1];
    assign pins.tdi      = s2[0];
endmodule
`default_nettype wire

/* File: tap_core.sv */
// Functional notes
// RULE1: State advances per test-clock rise using mode-select
// RULE2: Identification holds revision and device-type fields
// RULE3: Identification bits 11:1 hold maker code
// RULE4: Identification bit 0 always one
// RULE5: Code 000 captures pin ring
// RULE6: Code 001 captures and shifts identification
// RULE7: Code 010 captures, shifts ring, outputs high-impedance
// RULE8: Code 100 captures ring, shifts, memory unaffected
// RULE9: Code 111 selects one-bit bypass
// RULE10: Controller never loads codes 011, 101, 110; the code loads them from the shift register and shifts through the bypass bit
// RULE11: Sample data in on rise, drive out on fall
// RULE12: Five high mode-selects reset; identification instruction loaded
// RULE13: Capture-instruction loads 01 into low bits
// RULE14: Bit 108 gates outputs under external-test; preset high
// RULE15: Shift registers toward data out, LSB first
`include "tap_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tap_core import tap_pkg::*; #(
    parameter int BSR_W = `TAP_BSR_W
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // Test pins
    input  wire logic             tck,
    input  wire logic             tms,
    input  wire logic             tdi,
    output logic                  tdo,
    output logic                  tdo_oe_n,
    // Memory pin ring
    input  wire logic [BSR_W-1:0] ring_in,
    output logic      [BSR_W-1:0] ring_out,
    output logic                  extest_mode,
    output logic                  mem_out_hiz
);
    // Ring must be wide enough to hold the output-bus enable cell
    if (BSR_W <= `TAP_OE_BIT) begin
        $error("BSR_W too small");
    end

    localparam logic [`TAP_ID_W-1:0] ID_CODE =
        {`TAP_REV_VAL, `TAP_PART_VAL, `TAP_MAKER_VAL, 1'b1}; // Arbitrary values
    localparam logic [`TAP_IR_W-1:0] IR_CAP  = `TAP_IR_CAPTURE;

    tap_pins_if pins ();

    tap_pin_sync u_sync (
        .clk  (clk),
        .srst (srst),
        .tck  (tck),
        .tms  (tms),
        .tdi  (tdi),
        .pins (pins)
    );

    tap_state_t             state;
    logic [`TAP_IR_W-1:0]   ir_sh;
    logic [`TAP_IR_W-1:0]   ir;
    logic [`TAP_ID_W-1:0]   id_sh;
    logic                   byp;
    logic [BSR_W-1:0]       bsr_sh;
    logic [BSR_W-1:0]       bsr_up;

    tap_state_t             next_state;
    logic [`TAP_IR_W-1:0]   next_ir_sh;
    logic [`TAP_IR_W-1:0]   next_ir;
    logic [`TAP_ID_W-1:0]   next_id_sh;
    logic                   next_byp;
    logic [BSR_W-1:0]       next_bsr_sh;
    logic [BSR_W-1:0]       next_bsr_up;
    logic                   next_tdo;
    logic                   next_tdo_oe_n;
    logic                   next_extest_mode;
    logic                   next_mem_out_hiz;
    logic                   use_bsr;
    logic                   ser_out;

    always_comb begin
        next_state = state;
        if (pins.tck_rise) begin
            case (state) // RULE1
                ST_RESET:    next_state = pins.tms ? ST_RESET    : ST_IDLE;
                ST_IDLE:     next_state = pins.tms ? ST_SEL_DR   : ST_IDLE;
                ST_SEL_DR:   next_state = pins.tms ? ST_SEL_IR   : ST_CAP_DR;
                ST_CAP_DR:   next_state = pins.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_SHIFT_DR: next_state = pins.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_EXIT1_DR: next_state = pins.tms ? ST_UPD_DR   : ST_PAUSE_DR;
                ST_PAUSE_DR: next_state = pins.tms ? ST_EXIT2_DR : ST_PAUSE_DR;
                ST_EXIT2_DR: next_state = pins.tms ? ST_UPD_DR   : ST_SHIFT_DR;
                ST_UPD_DR:   next_state = pins.tms ? ST_SEL_DR   : ST_IDLE;
                ST_SEL_IR:   next_state = pins.tms ? ST_RESET    : ST_CAP_IR; // RULE12
                ST_CAP_IR:   next_state = pins.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_SHIFT_IR: next_state = pins.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_EXIT1_IR: next_state = pins.tms ? ST_UPD_IR   : ST_PAUSE_IR;
                ST_PAUSE_IR: next_state = pins.tms ? ST_EXIT2_IR : ST_PAUSE_IR;
                ST_EXIT2_IR: next_state = pins.tms ? ST_UPD_IR   : ST_SHIFT_IR;
                ST_UPD_IR:   next_state = pins.tms ? ST_SEL_DR   : ST_IDLE;
                default:     next_state = ST_RESET;
            endcase
        end
    end

    always_comb begin
        use_bsr = (ir == `TAP_OP_EXTEST) || (ir == `TAP_OP_HIGHZ) ||
                  (ir == `TAP_OP_SAMPLE); // RULE5 RULE7 RULE8
        next_ir_sh  = ir_sh;
        next_ir     = ir;
        next_id_sh  = id_sh;
        next_byp    = byp;
        next_bsr_sh = bsr_sh;
        next_bsr_up = bsr_up;
        if (pins.tck_rise) begin // RULE11
            case (state)
                ST_RESET: begin
                    next_ir = `TAP_OP_IDCODE; // RULE12
                    next_bsr_up[`TAP_OE_BIT] = 1'b1; // RULE14
                end
                ST_CAP_IR: next_ir_sh = {ir[`TAP_IR_W-1], IR_CAP[1:0]}; // RULE13
                ST_SHIFT_IR: next_ir_sh = {pins.tdi, ir_sh[`TAP_IR_W-1:1]}; // RULE15
                ST_UPD_IR: next_ir = ir_sh;
                ST_CAP_DR: begin
                    if (ir == `TAP_OP_IDCODE) next_id_sh = ID_CODE; // RULE2 RULE3 RULE4 RULE6
                    if (ir == `TAP_OP_BYPASS) next_byp = 1'b0; // RULE9
                    if (use_bsr) next_bsr_sh = ring_in; // RULE5 RULE7 RULE8
                end
                ST_SHIFT_DR: begin
                    if (ir == `TAP_OP_IDCODE) begin
                        next_id_sh = {pins.tdi, id_sh[`TAP_ID_W-1:1]}; // RULE15
                    end else if (use_bsr) begin
                        next_bsr_sh = {pins.tdi, bsr_sh[BSR_W-1:1]}; // RULE15
                    end else begin
                        next_byp = pins.tdi; // RULE9
                    end
                end
                ST_UPD_DR: if (use_bsr) next_bsr_up = bsr_sh;
                default: ;
            endcase
        end
    end

    always_comb begin
        if (state == ST_SHIFT_IR) ser_out = ir_sh[0];
        else if (ir == `TAP_OP_IDCODE) ser_out = id_sh[0];
        else if (use_bsr) ser_out = bsr_sh[0];
        else ser_out = byp;
        next_tdo      = tdo;
        next_tdo_oe_n = tdo_oe_n;
        if (pins.tck_fall) begin // RULE11
            next_tdo      = ser_out;
            next_tdo_oe_n = !((state == ST_SHIFT_IR) || (state == ST_SHIFT_DR));
        end
        next_extest_mode = (ir == `TAP_OP_EXTEST);
        next_mem_out_hiz = (ir == `TAP_OP_HIGHZ) ||
                           ((ir == `TAP_OP_EXTEST) && !bsr_up[`TAP_OE_BIT]); // RULE7 RULE14
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state       <= ST_RESET;
            ir_sh       <= `TAP_OP_IDCODE;
            ir          <= `TAP_OP_IDCODE; // RULE12
            id_sh       <= '0;
            byp         <= 1'b0;
            bsr_sh      <= '0;
            bsr_up      <= BSR_W'(1) << `TAP_OE_BIT; // RULE14
            tdo         <= 1'b0;
            tdo_oe_n    <= 1'b1;
            extest_mode <= 1'b0;
            mem_out_hiz <= 1'b0;
        end else begin
            state       <= next_state;
            ir_sh       <= next_ir_sh;
            ir          <= next_ir;
            id_sh       <= next_id_sh;
            byp         <= next_byp;
            bsr_sh      <= next_bsr_sh;
            bsr_up      <= next_bsr_up;
            tdo         <= next_tdo;
            tdo_oe_n    <= next_tdo_oe_n;
            extest_mode <= next_extest_mode;
            mem_out_hiz <= next_mem_out_hiz;
        end
    end

    assign ring_out = bsr_up;
endmodule
`default_nettype wire

/* File: tap_core_props.sv */
`timescale 1ns/1ps
`default_nettype none
module tap_core_chk #(parameter int BSR_W = 109) (
    // Clock and reset
    input wire logic             clk,
    input wire logic             srst,
    // Pins
    input wire logic             tck,
    input wire logic             tms,
    input wire logic             tdi,
    input wire logic             tdo,
    input wire logic             tdo_oe_n,
    input wire logic [BSR_W-1:0] ring_in,
    input wire logic [BSR_W-1:0] ring_out,
    input wire logic             extest_mode,
    input wire logic             mem_out_hiz
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence quiet_s; $stable(tck) [*8]; endsequence
    sequence ext_lo_s; (extest_mode && !ring_out[BSR_W-1]) [*2]; endsequence
    sequence ext_hi_s; (extest_mode && ring_out[BSR_W-1]) [*2]; endsequence
    AST_TDO_FALL: assert property ($changed(tdo) |-> !$past(tck, 2))
        else $error("tdo moved outside tck low");
    AST_OE_FALL: assert property ($changed(tdo_oe_n) |-> !$past(tck, 2))
        else $error("tdo enable moved outside tck low");
    AST_EXT_HIZ: assert property (ext_lo_s |-> mem_out_hiz)
        else $error("outputs not high impedance");
    AST_EXT_DRV: assert property (ext_hi_s |-> !mem_out_hiz)
        else $error("outputs not driven");
    AST_RST_VAL: assert property ($fell(srst) |-> ring_out[BSR_W-1] && !extest_mode
        && !mem_out_hiz && tdo_oe_n && ring_out[BSR_W-2:0] == '0)
        else $error("wrong state after reset");
    AST_QUIET: assert property (quiet_s |-> $stable(ring_out) && $stable(extest_mode)
        && $stable(tdo_oe_n))
        else $error("state moved without tck edge");
    AST_UPD_OUT: assert property ($changed(ring_out) |-> tdo_oe_n)
        else $error("ring_out moved while shifting");
    AST_INSTR: assert property ($changed(extest_mode) || $changed(mem_out_hiz)
        |-> tdo_oe_n)
        else $error("mode moved while shifting");
endmodule
bind tap_core tap_core_chk #(.BSR_W(BSR_W)) u_chk (.clk(clk), .srst(srst), .tck(tck),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .ring_in(ring_in),
    .ring_out(ring_out), .extest_mode(extest_mode), .mem_out_hiz(mem_out_hiz));
`default_nettype wire

/* File: tap_host.sv */
`timescale 1ns/1ps
`default_nettype none
module tap_host (
    // Test pins
    output var logic tck,
    output var logic tms,
    output var logic tdi,
    input wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // One tck period, tdo taken at the rise
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #24 tck = 1'b1;
        q = tdo;
        #20 tdi = ~d;
        #4 tck = 1'b0;
    endtask
    task automatic reset5();
        logic q;
        repeat (5) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask
    task automatic scan(input bit ir, input int n, input logic [108:0] din,
                        output logic [108:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b0, q);
        if (ir) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask
endmodule
`default_nettype wire

/* File: tb_tap_core.sv */
`include "tap_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_tap_core;
    localparam logic [31:0] ID = {`TAP_REV_VAL, `TAP_PART_VAL, `TAP_MAKER_VAL, 1'b1};
    localparam logic [108:0] PRE = 109'h1 << 108;
    localparam logic [108:0] PAT = {1'b1, {27{4'hc}}};
    localparam logic [108:0] PAT2 = {1'b0, {27{4'h6}}};
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic tck, tms, tdi, tdo, tdo_oe_n, extest_mode, mem_out_hiz;
    logic [108:0] ring_in = '0;
    logic [108:0] ring_out, dout;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    always #2.5 clk = ~clk;
    tap_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    tap_core u_dut (.clk(clk), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n), .ring_in(ring_in), .ring_out(ring_out),
        .extest_mode(extest_mode), .mem_out_hiz(mem_out_hiz));
    task automatic check(input string what, input logic [108:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic t_reset_id();
        check("ring_out", ring_out, PRE);
        check("flags", {extest_mode, mem_out_hiz, tdo_oe_n}, 3'b001);
        u_host.reset5();
        u_host.scan(1'b0, 32, '0, dout);
        check("id", dout[31:0], ID);
    endtask
    task automatic t_ir_bypass();
        u_host.scan(1'b1, 3, 109'h7, dout);
        check("ir capture", dout[1:0], 2'b01);
        u_host.scan(1'b0, 8, 109'had, dout);
        check("bypass", dout[7:0], 8'h5a);
    endtask
    task automatic t_sample();
        @(posedge clk);
        ring_in <= PAT;
        u_host.scan(1'b1, 3, 109'h4, dout);
        u_host.scan(1'b0, 109, PAT2, dout);
        check("sample", dout, PAT);
        check("preload", ring_out, PAT2);
        check("flags", {extest_mode, mem_out_hiz}, 2'b00);
    endtask
    task automatic t_extest();
        u_host.scan(1'b1, 3, 109'h0, dout);
        check("ext off", {extest_mode, mem_out_hiz}, 2'b11);
        u_host.scan(1'b0, 109, PAT, dout);
        check("ext capture", dout, PAT);
        check("ext on", {extest_mode, mem_out_hiz}, 2'b10);
        u_host.scan(1'b1, 3, 109'h2, dout);
        check("highz", {extest_mode, mem_out_hiz}, 2'b01);
        u_host.scan(1'b0, 109, PAT2, dout);
        check("hz capture", dout, PAT);
        u_host.reset5();
        check("reset", {ring_out[108], extest_mode, mem_out_hiz}, 3'b100);
        u_host.scan(1'b0, 32, '0, dout);
        check("id again", dout[31:0], ID);
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset_id();
        t_ir_bypass();
        t_sample();
        t_extest();
        wrap_up();
    end
endmodule
`default_nettype wire
